// [hdl/bstc_timer.sv]
// Buffered sixteen-bit timer/counter with prescaler, wide access, APB registers and interrupt.
// What this block does
// - Counts only while run bit is set.
// - Internal source counts once per four clocks.
// - External source counts rising edges after falling.
// - Sync bit chooses synchronised or bypassed external.
// - Prescaler divides by one, two, four, eight.
// - Timebase field splits compare units between pairs.
// - Three modes: timer, sync counter, async counter.
// - Oscillator enable forces pins input, reads zero.
// - Wide bit selects buffered sixteen-bit access.
// - Low byte read latches high into buffer.
// - High write buffers; low write loads both.
// - Wide mode high address reaches buffer only.
// - Low write clears prescaler; high write not.
// - Wrap to zero sets overflow flag, interrupt.
// - Assigned compare trigger resets counter, not async.
// - Software write beats trigger reset.
// - Trigger reset never sets overflow flag.
`include "bstc_params.svh"
module bstc_timer
  import bstc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_clock_pin,
  input wire logic osc_clock,
  input wire logic [1:0] port_direction_bits,
  input wire logic [1:0] osc_pins_in,
  input wire bstc_ccp_t ccp_in,
  output logic [1:0] osc_pins_oe,
  output logic [4:0] ccp_timebase_this,
  output logic irq
);
  bstc_control_t counter_control_q;
  logic osc_en_q;
  logic [7:0] count_low_byte_q, count_high_byte_q, high_buffer_q;
  logic [2:0] presc_q;
  logic [1:0] inst_div_q;
  logic ext_s1_q, ext_s2_q, osc_s1_q, osc_s2_q, ext_prev_q, armed_q;
  logic [1:0] pin_s1_q, pin_s2_q;
  logic irq_status_q, irq_mask_q;
  logic [31:0] prdata_q;
  logic irq_q;
  logic pready_q;
  logic [1:0] osc_oe_q;
  logic [4:0] tb_q;
  bstc_mode_t mode;
  logic wr, rd, wr_low, wr_high, rd_low, tick, presc_tick, trig, wrap, ext_lvl, ext_in;
  logic [15:0] count;
  logic [2:0] presc_limit;
  logic [4:0] tb_mask;

  // APB: zero wait states once ready is up, every access finishes in its access phase.
  assign wr = psel && penable && pwrite && pready_q;
  assign rd = psel && penable && !pwrite && pready_q;
  assign wr_low = wr && paddr == `BSTC_OFF_COUNT_LOW && pstrb[0];
  assign wr_high = wr && paddr == `BSTC_OFF_COUNT_HIGH && pstrb[0];
  assign rd_low = rd && paddr == `BSTC_OFF_COUNT_LOW;
  assign count = {count_high_byte_q, count_low_byte_q};

  // External sources: pin and oscillator each pass two flops of their own before the choice.
  // Choosing first would put a gate in front of the first flop and widen its metastable window.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      pin_s1_q <= 2'b00;
      pin_s2_q <= 2'b00;
    end else begin
      ext_s1_q <= ext_clock_pin;
      ext_s2_q <= ext_s1_q;
      osc_s1_q <= osc_clock;
      osc_s2_q <= osc_s1_q;
      pin_s1_q <= osc_pins_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Synchronised level of whichever source the oscillator enable selects.
  assign ext_lvl = osc_en_q ? osc_s2_q : ext_s2_q;

  // The bypass path skips the clock-aligning edge stage; true asynchronous counting is
  // not possible on one clock, so bypass only shortens the path by one flop.
  assign ext_in = counter_control_q.ext_sync_bypass ? ext_lvl : ext_prev_q;

  // Mode decode from source select and sync bit.
  always_comb begin
    if (!counter_control_q.ext_clock_select) begin
      mode = BSTC_MODE_TIMER;
    end else if (counter_control_q.ext_sync_bypass) begin
      mode = BSTC_MODE_ASYNC_CNT;
    end else begin
      mode = BSTC_MODE_SYNC_CNT;
    end
  end

  // Edge detection; a rising edge only counts once a falling edge has been seen.
  logic ext_prev2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev_q <= 1'b0;
      ext_prev2_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_lvl;
      ext_prev2_q <= ext_in;
      if (!counter_control_q.ext_clock_select) begin
        armed_q <= 1'b0;
      end else if (ext_prev2_q && !ext_in) begin
        armed_q <= 1'b1;
      end
    end
  end

  // Instruction-cycle divider gives one enable every four clocks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inst_div_q <= 2'd0;
    end else begin
      inst_div_q <= inst_div_q + 2'd1;
    end
  end

  always_comb begin
    if (counter_control_q.ext_clock_select) begin
      tick = armed_q && !ext_prev2_q && ext_in;
    end else begin
      tick = inst_div_q == `BSTC_INST_DIV;
    end
  end

  // Prescaler: counts input ticks and passes every 1st, 2nd, 4th or 8th.
  // A new prescale code keeps the partial count; software writes the low byte to restart it.
  assign presc_limit = 3'((4'd1 << counter_control_q.input_prescale_sel) - 4'd1);
  assign presc_tick = counter_control_q.counter_run && tick && presc_q == presc_limit;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= 3'd0;
    end else if (wr_low) begin
      presc_q <= 3'd0;
    end else if (presc_tick) begin
      presc_q <= 3'd0;
    end else if (counter_control_q.counter_run && tick) begin
      presc_q <= presc_q + 3'd1;
    end
  end

  // Timebase split for the five compare units, bit 0 is the first unit.
  always_comb begin
    unique case ({counter_control_q.ccp_tb_high, counter_control_q.ccp_tb_low})
      `BSTC_SEL_ALL_THIS: tb_mask = `BSTC_MASK_ALL;
      `BSTC_SEL_THREE_THIS: tb_mask = `BSTC_MASK_THREE;
      `BSTC_SEL_FOUR_THIS: tb_mask = `BSTC_MASK_FOUR;
      default: tb_mask = `BSTC_MASK_NONE;
    endcase
  end
  // Trigger is honoured only outside the asynchronous counter mode.
  assign trig = |(tb_mask & ccp_in.trigger & ccp_in.event_mode) && mode != BSTC_MODE_ASYNC_CNT;
  assign wrap = presc_tick && count == `BSTC_COUNT_MAX;

  // Counter low byte; a write wins over a trigger, which wins over counting.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_low_byte_q <= 8'h00;
    end else if (wr_low) begin
      count_low_byte_q <= pwdata[7:0];
    end else if (trig) begin
      count_low_byte_q <= 8'h00;
    end else if (presc_tick) begin
      count_low_byte_q <= count_low_byte_q + 8'h01;
    end
  end

  // Counter high byte; in wide mode only a low write loads it, from the buffer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_high_byte_q <= 8'h00;
    end else if (wr_low && counter_control_q.wide_access_enable) begin
      count_high_byte_q <= high_buffer_q;
    end else if (wr_high && !counter_control_q.wide_access_enable) begin
      count_high_byte_q <= pwdata[7:0];
    end else if (trig && !wr_low) begin
      count_high_byte_q <= 8'h00;
    end else if (presc_tick && count_low_byte_q == `BSTC_BYTE_MAX && !wr_low) begin
      count_high_byte_q <= count_high_byte_q + 8'h01;
    end
  end

  // High byte buffer: written by high writes, loaded on low reads in wide mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_buffer_q <= 8'h00;
    end else if (counter_control_q.wide_access_enable && wr_high) begin
      high_buffer_q <= pwdata[7:0];
    end else if (counter_control_q.wide_access_enable && rd_low) begin
      high_buffer_q <= count_high_byte_q;
    end
  end

  // Control, oscillator enable and mask registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_control_q <= `BSTC_CONTROL_RESET;
      osc_en_q <= 1'b0;
      irq_mask_q <= 1'b0;
    end else if (wr && pstrb[0]) begin
      if (paddr == `BSTC_OFF_CONTROL) begin
        counter_control_q <= pwdata[7:0];
      end
      if (paddr == `BSTC_OFF_PIN_CTRL) begin
        osc_en_q <= pwdata[`BSTC_BIT_OSC_EN];
      end
      if (paddr == `BSTC_OFF_IRQ_MASK) begin
        irq_mask_q <= pwdata[0];
      end
    end
  end

  // Overflow flag: set wins over a write-one clear; trigger resets never set it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= 1'b0;
    end else if (wrap && !wr_low && !trig) begin
      irq_status_q <= 1'b1;
    end else if (wr && pstrb[0] && paddr == `BSTC_OFF_IRQ_STATUS && pwdata[0]) begin
      irq_status_q <= 1'b0;
    end
  end

  // Registered outputs: interrupt, pin enables, timebase map.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
      osc_oe_q <= 2'b00;
      tb_q <= 5'b0_0000;
    end else begin
      irq_q <= irq_status_q && irq_mask_q;
      osc_oe_q <= osc_en_q ? 2'b00 : ~port_direction_bits;
      tb_q <= tb_mask;
    end
  end

  // Ready rises one clock after reset ends, so every output is quiet while reset is held.
  // After that the bus never waits, which keeps the low byte access a single clean cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= 1'b1;
    end
  end

  // Read data registered in the setup phase so it stands during the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      unique case (paddr)
        `BSTC_OFF_CONTROL: prdata_q <= {24'h00_0000, counter_control_q};
        `BSTC_OFF_COUNT_LOW: prdata_q <= {24'h00_0000, count_low_byte_q};
        `BSTC_OFF_COUNT_HIGH: prdata_q <= {24'h00_0000, counter_control_q.wide_access_enable ?
                                           high_buffer_q : count_high_byte_q};
        `BSTC_OFF_IRQ_STATUS: prdata_q <= {31'h0000_0000, irq_status_q};
        `BSTC_OFF_IRQ_MASK: prdata_q <= {31'h0000_0000, irq_mask_q};
        `BSTC_OFF_PIN_CTRL: prdata_q <= {31'h0000_0000, osc_en_q};
        `BSTC_OFF_PORT_READ: prdata_q <= {30'h0000_0000, osc_en_q ? 2'b00 : pin_s2_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = 1'b0;
  assign irq = irq_q;
  assign osc_pins_oe = osc_oe_q;
  assign ccp_timebase_this = tb_q;

  // Checks on the counting and access behaviour.
  stop_holds_a: assert property (@(posedge pclk) disable iff (!presetn)
    !counter_control_q.counter_run && !wr && !trig |=> $stable(count)) else $error("count moved while stopped");
  inst_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !counter_control_q.ext_clock_select && tick |=> !tick [*3]) else $error("internal tick too often");
  presc_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_low |=> presc_q == 3'd0) else $error("low write kept prescaler");
  buffer_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    counter_control_q.wide_access_enable && rd_low && !wr |=> high_buffer_q == $past(count_high_byte_q))
    else $error("buffer not loaded");
  wide_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    counter_control_q.wide_access_enable && wr_low |=> count_high_byte_q == $past(high_buffer_q))
    else $error("high not loaded from buffer");
  write_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_low && trig |=> count_low_byte_q == $past(pwdata[7:0])) else $error("trigger beat write");
  trig_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    trig && !wr_low && !wr_high |=> count == 16'h0000) else $error("trigger missed");
  wrap_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    wrap && !wr_low && !trig |=> count == 16'h0000 && irq_status_q) else $error("wrap lost");
  trig_noflag_a: assert property (@(posedge pclk) disable iff (!presetn)
    trig && !irq_status_q |=> !irq_status_q) else $error("trigger set flag");
  osc_input_a: assert property (@(posedge pclk) disable iff (!presetn)
    osc_en_q [*2] |-> osc_pins_oe == 2'b00) else $error("osc pins driven");

  // Checks on the byte paths, the edge arming, the timebase map and the interrupt output.
  presc_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_high && !counter_control_q.counter_run |=> $stable(presc_q)) else $error("high write moved prescaler");
  byte_carry_a: assert property (@(posedge pclk) disable iff (!presetn)
    !counter_control_q.wide_access_enable && presc_tick && count_low_byte_q == `BSTC_BYTE_MAX && !wr && !trig
    |=> count_high_byte_q == $past(count_high_byte_q) + 8'h01) else $error("low byte did not carry");
  wide_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    counter_control_q.wide_access_enable && wr_high && !trig && !presc_tick |=> $stable(count_high_byte_q))
    else $error("wide high write reached counter");
  arm_first_a: assert property (@(posedge pclk) disable iff (!presetn)
    counter_control_q.ext_clock_select && !armed_q |-> !tick) else $error("edge counted before a fall");
  async_notrig_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode == BSTC_MODE_ASYNC_CNT |-> !trig) else $error("trigger honoured in async mode");
  tb_all_a: assert property (@(posedge pclk) disable iff (!presetn)
    counter_control_q.ccp_tb_high && counter_control_q.ccp_tb_low |=> ccp_timebase_this == `BSTC_MASK_ALL)
    else $error("timebase map wrong");
  irq_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq_status_q && irq_mask_q |=> irq) else $error("interrupt not raised");
  irq_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(irq_status_q && irq_mask_q) |=> !irq) else $error("interrupt not dropped");
  port_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    osc_en_q && psel && !penable && paddr == `BSTC_OFF_PORT_READ |=> prdata == 32'h0000_0000)
    else $error("port read not zero");

  // Main scenarios that the bench is expected to reach.
  wrap_c: cover property (@(posedge pclk) disable iff (!presetn) wrap);
  trig_c: cover property (@(posedge pclk) disable iff (!presetn) trig);
  ext_c: cover property (@(posedge pclk) disable iff (!presetn) presc_tick && counter_control_q.ext_clock_select);
  wide_c: cover property (@(posedge pclk) disable iff (!presetn) counter_control_q.wide_access_enable && wr_low);
  osc_c: cover property (@(posedge pclk) disable iff (!presetn)
    presc_tick && osc_en_q && counter_control_q.ext_clock_select);
endmodule : bstc_timer

// [hdl/bstc_params.svh]
// Offsets, field positions, reset values and encodings of the buffered timer/counter.
`ifndef BSTC_PARAMS_SVH
`define BSTC_PARAMS_SVH
`define BSTC_OFF_CONTROL 12'h000
`define BSTC_OFF_COUNT_LOW 12'h004
`define BSTC_OFF_COUNT_HIGH 12'h008
`define BSTC_OFF_IRQ_STATUS 12'h00C
`define BSTC_OFF_IRQ_MASK 12'h010
`define BSTC_OFF_PIN_CTRL 12'h014
`define BSTC_OFF_PORT_READ 12'h018
`define BSTC_CONTROL_RESET 8'h00
`define BSTC_BIT_RUN 0
`define BSTC_BIT_EXT_SEL 1
`define BSTC_BIT_SYNC_BYPASS 2
`define BSTC_BIT_TB_LOW 3
`define BSTC_BIT_PS_LO 4
`define BSTC_BIT_PS_HI 5
`define BSTC_BIT_TB_HIGH 6
`define BSTC_BIT_WIDE 7
`define BSTC_BIT_OSC_EN 0
`define BSTC_INST_DIV 2'd3
`define BSTC_COUNT_MAX 16'hFFFF
`define BSTC_BYTE_MAX 8'hFF
`define BSTC_SEL_ALL_THIS 2'b11
`define BSTC_SEL_THREE_THIS 2'b10
`define BSTC_SEL_FOUR_THIS 2'b01
`define BSTC_MASK_ALL 5'b1_1111
`define BSTC_MASK_THREE 5'b1_1100
`define BSTC_MASK_FOUR 5'b1_1110
`define BSTC_MASK_NONE 5'b0_0000
`endif

// [hdl/bstc_pkg.sv]
// Types shared by the buffered timer/counter.
package bstc_pkg;
  typedef enum logic [2:0] {
    BSTC_MODE_TIMER = 3'b001,
    BSTC_MODE_SYNC_CNT = 3'b010,
    BSTC_MODE_ASYNC_CNT = 3'b100
  } bstc_mode_t;

  typedef struct packed {
    logic wide_access_enable;
    logic ccp_tb_high;
    logic [1:0] input_prescale_sel;
    logic ccp_tb_low;
    logic ext_sync_bypass;
    logic ext_clock_select;
    logic counter_run;
  } bstc_control_t;

  typedef struct packed {
    logic [4:0] trigger;
    logic [4:0] event_mode;
  } bstc_ccp_t;
endpackage : bstc_pkg

// [verification/bstc_ext_src.sv]
// Model of the far-side count source: a pin clock or a low-power oscillator.
module bstc_ext_src (
  input wire logic pclk,
  input wire logic go,
  input wire logic use_osc,
  input wire logic [7:0] n_pulses,
  output logic ext_clock_pin,
  output logic osc_clock,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_q = 8'h00;
  logic [3:0] ph_q = 4'h0;
  logic lvl;
  // Each pulse is eight clocks high, eight low, so the synchroniser sees every level.
  always_ff @(posedge pclk) begin
    if (go && left_q == 8'h00) begin
      left_q <= n_pulses;
      ph_q <= 4'h0;
    end else if (left_q != 8'h00) begin
      ph_q <= ph_q + 4'h1;
      if (ph_q == 4'hF) begin
        left_q <= left_q - 8'h01;
      end
    end
  end
  // The clock stands low between frames, as a stopped source would.
  assign lvl = (left_q != 8'h00) && !ph_q[3];
  assign ext_clock_pin = lvl && !use_osc;
  assign osc_clock = lvl && use_osc;
  assign busy = (left_q != 8'h00);
endmodule : bstc_ext_src

// [verification/bstc_timer_tb_top.sv]
// Self-checking bench of the buffered timer/counter.
`include "bstc_params.svh"
module bstc_timer_tb_top
  import bstc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] a_ct = `BSTC_OFF_CONTROL;
  localparam logic [11:0] a_lo = `BSTC_OFF_COUNT_LOW;
  localparam logic [11:0] a_hi = `BSTC_OFF_COUNT_HIGH;
  localparam logic [11:0] a_st = `BSTC_OFF_IRQ_STATUS;
  localparam logic [11:0] a_mk = `BSTC_OFF_IRQ_MASK;
  localparam logic [11:0] a_pc = `BSTC_OFF_PIN_CTRL;
  localparam logic [11:0] a_pr = `BSTC_OFF_PORT_READ;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ext_clock_pin;
  logic osc_clock;
  logic [1:0] port_direction_bits = 2'b01;
  logic [1:0] osc_pins_in = 2'b11;
  bstc_ccp_t ccp_in = '0;
  logic [1:0] osc_pins_oe;
  logic [4:0] ccp_timebase_this;
  logic irq;
  logic go = 1'b0;
  logic use_osc = 1'b0;
  logic busy;
  logic [31:0] r;
  logic err;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  always #2.5 pclk = ~pclk;
  bstc_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clock_pin(ext_clock_pin), .osc_clock(osc_clock), .port_direction_bits(port_direction_bits),
    .osc_pins_in(osc_pins_in), .ccp_in(ccp_in), .osc_pins_oe(osc_pins_oe),
    .ccp_timebase_this(ccp_timebase_this), .irq(irq));
  bstc_ext_src src (.pclk(pclk), .go(go), .use_osc(use_osc), .n_pulses(8'h05),
    .ext_clock_pin(ext_clock_pin), .osc_clock(osc_clock), .busy(busy));
  // One APB transfer; the optional trigger is sampled at the access edge only.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [4:0] t);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    ccp_in.trigger <= t;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    ccp_in.trigger <= 5'b0_0000;
    @(posedge pclk);
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Start phase against the free divider is unknown, so a count is allowed a window.
  task automatic chk_in(input string nm, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] g);
    logic ok;
    ok = (g >= lo) && (g <= hi);
    n_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("BAD %s expected %h..%h seen %h", nm, lo, hi, g);
    end
  endtask : chk_in
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  task automatic t_reset();
    apb(0, a_ct, '0, '0);
    chk("control", 32'h0000_0000, r); // [register]
    chk("irq", 32'h0000_0000, 32'(irq));
    apb(0, 12'h0FC, '0, '0);
    chk("unmapped", 32'h0000_0000, r);
    chk("slverr", 32'h0000_0000, 32'(err)); // [register]
    $display("test reset done");
  endtask : t_reset
  // Each prescale code runs 64 times its ratio, so sixteen counts are expected.
  task automatic t_prescale();
    logic [31:0] h;
    for (int p = 0; p < 4; p++) begin
      apb(1, a_hi, '0, '0);
      apb(1, a_lo, 32'h0000_00F8, '0);
      apb(1, a_ct, 32'(p * 16 + 1), '0);
      repeat ((64 << p) - 2) @(posedge pclk);
      apb(1, a_ct, 32'(p * 16), '0);
      apb(0, a_lo, '0, '0);
      chk_in("count_low", 32'h0000_0007, 32'h0000_0009, r);
      h = r;
      repeat (40) @(posedge pclk);
      apb(0, a_lo, '0, '0);
      chk("count_hold", h, r);
      apb(0, a_hi, '0, '0);
      chk("count_high", 32'h0000_0001, r);
    end
    $display("test prescale done");
  endtask : t_prescale
  task automatic t_wide();
    apb(1, a_ct, 32'h0000_0080, '0);
    apb(1, a_hi, 32'h0000_00AB, '0);
    apb(1, a_lo, 32'h0000_00CD, '0);
    apb(0, a_lo, '0, '0);
    chk("wide_low", 32'h0000_00CD, r);
    apb(0, a_hi, '0, '0);
    chk("wide_high", 32'h0000_00AB, r);
    apb(1, a_hi, 32'h0000_0055, '0);
    apb(0, a_hi, '0, '0);
    chk("buffer", 32'h0000_0055, r);
    apb(0, a_lo, '0, '0);
    apb(0, a_hi, '0, '0);
    chk("latched_high", 32'h0000_00AB, r);
    apb(1, a_ct, '0, '0);
    $display("test wide done");
  endtask : t_wide
  task automatic t_irq();
    apb(1, a_hi, 32'h0000_00FF, '0);
    apb(1, a_lo, 32'h0000_00F0, '0);
    apb(1, a_ct, 32'h0000_0001, '0);
    repeat (100) @(posedge pclk);
    apb(1, a_ct, '0, '0);
    apb(0, a_hi, '0, '0);
    chk("wrap_high", 32'h0000_0000, r);
    apb(0, a_st, '0, '0);
    chk("status", 32'h0000_0001, r);
    chk("irq_masked", 32'h0000_0000, 32'(irq));
    apb(1, a_mk, 32'h0000_0001, '0);
    @(posedge pclk);
    chk("irq_on", 32'h0000_0001, 32'(irq));
    apb(1, a_st, 32'h0000_0001, '0);
    @(posedge pclk);
    chk("irq_off", 32'h0000_0000, 32'(irq));
    $display("test irq done");
  endtask : t_irq
  task automatic t_trig();
    ccp_in.event_mode <= 5'b1_0000;
    apb(1, a_ct, 32'h0000_0048, '0);
    apb(1, a_hi, 32'h0000_0012, '0);
    apb(1, a_lo, 32'h0000_0034, '0);
    apb(0, 12'h0FC, '0, 5'b1_0000);
    apb(0, a_lo, '0, '0);
    chk("trig_low", 32'h0000_0000, r);
    apb(0, a_st, '0, '0);
    chk("trig_status", 32'h0000_0000, r);
    apb(1, a_lo, 32'h0000_0078, 5'b1_0000);
    apb(0, a_lo, '0, '0);
    chk("write_wins", 32'h0000_0078, r);
    apb(1, a_ct, 32'h0000_004E, '0);
    apb(0, 12'h0FC, '0, 5'b1_0000);
    apb(0, a_lo, '0, '0);
    chk("async_no_reset", 32'h0000_0078, r);
    $display("test trigger done");
  endtask : t_trig
  task automatic t_tb();
    logic [4:0] m[4] = '{5'b0_0000, 5'b1_1110, 5'b1_1100, 5'b1_1111};
    for (int c = 0; c < 4; c++) begin
      apb(1, a_ct, 32'(c[1] * 64 + c[0] * 8), '0);
      @(posedge pclk);
      chk("timebase", 32'(m[c]), 32'(ccp_timebase_this));
    end
    $display("test timebase done");
  endtask : t_tb
  task automatic frame();
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    wait (busy === 1'b0);
    repeat (8) @(posedge pclk);
  endtask : frame
  // The pin idles low at selection, so the first rising edge after selection is skipped; later frames count every edge.
  task automatic t_ext();
    apb(1, a_ct, 32'h0000_0002, '0);
    apb(1, a_lo, '0, '0);
    apb(1, a_ct, 32'h0000_0003, '0);
    frame();
    apb(0, a_lo, '0, '0);
    chk("sync_count", 32'h0000_0004, r);
    apb(1, a_ct, 32'h0000_0007, '0);
    apb(1, a_lo, '0, '0);
    frame();
    apb(0, a_lo, '0, '0);
    chk("async_count", 32'h0000_0005, r);
    apb(1, a_ct, '0, '0);
    $display("test external done");
  endtask : t_ext
  task automatic t_pins();
    chk("pin_oe", 32'h0000_0002, 32'(osc_pins_oe));
    apb(0, a_pr, '0, '0);
    chk("port_read", 32'h0000_0003, r);
    apb(1, a_pc, 32'h0000_0001, '0);
    @(posedge pclk);
    chk("osc_oe", 32'h0000_0000, 32'(osc_pins_oe));
    apb(0, a_pr, '0, '0);
    chk("osc_read", 32'h0000_0000, r);
    use_osc <= 1'b1;
    apb(1, a_ct, 32'h0000_0002, '0);
    apb(1, a_lo, '0, '0);
    apb(1, a_ct, 32'h0000_0003, '0);
    frame();
    apb(0, a_lo, '0, '0);
    chk("osc_count", 32'h0000_0004, r);
    apb(1, a_ct, '0, '0);
    $display("test pins done");
  endtask : t_pins
  // A hang is cut short at 20000 cycles, over ten times the cycles the tests need.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_prescale();
    t_wide();
    t_irq();
    t_trig();
    t_tb();
    t_ext();
    t_pins();
    tally_and_finish();
  end
endmodule : bstc_timer_tb_top
